/* File: include/csp_pkg.sv */
package csp_pkg;

  ////////////////////////////////////////////////////////////////////////
  // register byte offsets and buffer page numbers on the bus
  localparam logic [7:0] ADR_CTRL_ONE = 8'h00;
  localparam logic [7:0] ADR_CTRL_TWO = 8'h04;
  localparam logic [7:0] ADR_TX_SLOT = 8'h08;
  localparam logic [7:0] ADR_RX_SLOT = 8'h0c;
  localparam logic [7:0] ADR_STATUS = 8'h10;
  localparam logic [3:0] ADR_TXBUF_PAGE = 4'h2;
  localparam logic [3:0] ADR_RXBUF_PAGE = 4'h3;

  ////////////////////////////////////////////////////////////////////////
  // framing modes
  localparam logic [1:0] MODE_MULTI = 2'h0;
  localparam logic [1:0] MODE_I2S = 2'h1;
  localparam logic [1:0] MODE_ACLINK = 2'h2;

  ////////////////////////////////////////////////////////////////////////
  // counts and reset values
  localparam int NUM_BUF = 4;
  localparam logic [1:0] TRANSMIT_EMPTY_FLAG_DELAY = 2'h3;
  localparam logic [8:0] STOP_LEAD = 9'h003;
  localparam logic [15:0] SLOT_RST = 16'h0000;
  localparam logic [15:0] BUF_RST = 16'h0000;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////
  // control fields
  typedef struct packed {
    logic enable;
    logic sync_dir;
    logic [1:0] mode;
    logic [1:0] buffer_length_field;
    logic [3:0] wpf;
    logic [3:0] ws;
  } csp_ctrl_type;

  localparam csp_ctrl_type CTRL_RST = '{1'b0, 1'b0, 2'h0, 2'h0, 4'h0, 4'h0};

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_RUN = 3'b100
  } csp_state_type;

endpackage : csp_pkg

/* File: src/csp_codec_port.sv */
`timescale 1ns/1ns
module csp_codec_port (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  input wire logic we_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic bit_clock_pin_i,
  input wire logic frame_sync_pin_i,
  input wire logic sdi_i,
  output logic frame_sync_pin_o,
  output logic frame_sync_pin_oe_o,
  output logic sdo_o,
  output logic sdo_oe_o,
  output logic module_irq_flag_o
);

  ////////////////////////////////////////////////////////////////////////
  // functions
  function automatic logic slot_on(input logic [15:0] m,
                                   input logic [3:0] i);
    slot_on = m[i];
  endfunction : slot_on

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] dat,
                                          input logic [1:0] sel);
    merge16 = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
  endfunction : merge16

  ////////////////////////////////////////////////////////////////////////
  // storage
  csp_pkg::csp_ctrl_type ctrl;
  csp_pkg::csp_state_type state;
  csp_pkg::csp_state_type next_state;
  logic [15:0] tx_slot;
  logic [15:0] rx_slot;
  logic [15:0] txbuf [csp_pkg::NUM_BUF];
  logic [15:0] rxbuf [csp_pkg::NUM_BUF];
  logic [15:0] tx_shadow [csp_pkg::NUM_BUF];
  logic [15:0] rx_shadow [csp_pkg::NUM_BUF];
  logic [15:0] rx_word;
  logic [3:0] bit_cnt;
  logic [3:0] word_cnt;
  logic [1:0] bidx;
  logic [1:0] tm_cnt;
  logic stop_pending;
  logic transmit_empty_flag;
  logic receive_full_flag;
  logic receive_overflow_flag;
  logic bclk_meta, bclk_s, bclk_d;
  logic fs_meta, fs_s, fs_prev;
  logic sdi_meta, sdi_s;

  ////////////////////////////////////////////////////////////////////////
  // bus decode
  wire req = cyc_i & stb_i & ~ack_o;
  wire wr = req & we_i;
  wire rd = req & ~we_i;
  wire [1:0] idx = adr_i[3:2];
  wire hit_tx = adr_i[7:4] == csp_pkg::ADR_TXBUF_PAGE;
  wire hit_rx = adr_i[7:4] == csp_pkg::ADR_RXBUF_PAGE;
  wire hit_c1 = adr_i == csp_pkg::ADR_CTRL_ONE;
  wire hit_c2 = adr_i == csp_pkg::ADR_CTRL_TWO;
  wire hit_ts = adr_i == csp_pkg::ADR_TX_SLOT;
  wire hit_rs = adr_i == csp_pkg::ADR_RX_SLOT;
  wire hit_st = adr_i == csp_pkg::ADR_STATUS;
  wire [15:0] ctrl_one = {ctrl.enable, 6'h00, ctrl.sync_dir, 6'h00, ctrl.mode};
  wire [15:0] ctrl_two = {4'h0, ctrl.buffer_length_field, 1'b0, ctrl.wpf, 1'b0, ctrl.ws};
  wire [15:0] c1_new = merge16(ctrl_one, dat_i[15:0], sel_i[1:0]);
  wire [15:0] c2_new = merge16(ctrl_two, dat_i[15:0], sel_i[1:0]);
  wire run = state == csp_pkg::ST_RUN;
  wire waiting = state == csp_pkg::ST_WAIT;
  wire idle = state == csp_pkg::ST_IDLE;
  wire [3:0] slot_field = run ? word_cnt : 4'h0;
  wire [15:0] status = {4'h0, 1'b0, slot_field, 2'h0,
                        module_irq_flag_o, receive_overflow_flag, receive_full_flag, 1'b0, transmit_empty_flag};
  wire [15:0] rd_half = hit_c1 ? ctrl_one :
                        hit_c2 ? ctrl_two :
                        hit_ts ? tx_slot :
                        hit_rs ? rx_slot :
                        hit_st ? status :
                        hit_tx ? txbuf[idx] :
                        hit_rx ? rxbuf[idx] : 16'h0000;
  wire [31:0] rd_word = {16'h0000, rd_half};

  ////////////////////////////////////////////////////////////////////////
  // link sampling and frame arithmetic
  wire tick = bclk_s & ~bclk_d;
  wire last_bit = bit_cnt == ctrl.ws;
  wire last_word = word_cnt == ctrl.wpf;
  wire frame_end = tick & run & last_bit & last_word;
  wire [8:0] word_len = {5'h00, ctrl.ws} + 9'h001;
  wire [8:0] frame_len = 9'(({5'h00, ctrl.wpf} + 9'h001) * word_len);
  wire [8:0] pos = 9'({5'h00, word_cnt} * word_len) + {5'h00, bit_cnt};
  wire tx_on = slot_on(tx_slot, word_cnt);
  wire rx_on = slot_on(rx_slot, word_cnt);
  wire word_done = tick & run & last_bit & (tx_on | rx_on);
  wire xfer = word_done & (bidx == ctrl.buffer_length_field);
  wire sync_evt = (ctrl.mode == csp_pkg::MODE_I2S) ? (fs_s ^ fs_prev) : fs_s;
  // a master also waits for a bit clock edge so that bit 0 lasts a full bit
  wire slave_go = tick & ctrl.enable & (~ctrl.sync_dir | sync_evt);
  wire start = idle & ctrl.enable;
  wire enter_idle = (frame_end & stop_pending) |
                    (waiting & ~ctrl.enable);
  wire rx_move = xfer | (enter_idle & (bidx != 2'h0));
  wire tx_move = xfer | start;
  wire stop_mark = tick & run & ~ctrl.enable &
                   (pos + csp_pkg::STOP_LEAD == frame_len);
  wire [15:0] bit_mask = 16'h8000 >> bit_cnt;
  wire [15:0] rx_now = sdi_s ? (rx_word | bit_mask) :
                       (rx_word & ~bit_mask);
  wire transmit_empty_flag_set = xfer | (tm_cnt == 2'h1);
  wire transmit_empty_flag_clr = wr & hit_tx;
  wire receive_full_flag_set = rx_move;
  wire receive_full_flag_clr = rd & hit_rx;
  wire rov_clr = wr & hit_st & sel_i[0] & dat_i[3];

  assign next_state = start ? csp_pkg::ST_WAIT :
                      enter_idle ? csp_pkg::ST_IDLE :
                      (waiting & slave_go) ? csp_pkg::ST_RUN :
                      (frame_end & ctrl.sync_dir & ~slave_go) ?
                        csp_pkg::ST_WAIT : state;

  ////////////////////////////////////////////////////////////////////////
  // synchronisers
  always_ff @(posedge clk_i)
  begin
    bclk_meta <= bit_clock_pin_i;
    bclk_s <= bclk_meta;
    bclk_d <= bclk_s;
    fs_meta <= frame_sync_pin_i;
    fs_s <= fs_meta;
    sdi_meta <= sdi_i;
    sdi_s <= sdi_meta;
  end

  ////////////////////////////////////////////////////////////////////////
  // bus slave
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= csp_pkg::UNMAPPED_DATA;
    end
    else
    begin
      ack_o <= req;
      dat_o <= rd ? rd_word : dat_o;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl <= csp_pkg::CTRL_RST;
      tx_slot <= csp_pkg::SLOT_RST;
      rx_slot <= csp_pkg::SLOT_RST;
    end
    else
    begin
      if (wr & hit_c1)
        {ctrl.enable, ctrl.sync_dir, ctrl.mode} <=
          {c1_new[15], c1_new[8], c1_new[1:0]};
      if (wr & hit_c2)
        {ctrl.buffer_length_field, ctrl.wpf, ctrl.ws} <=
          {c2_new[11:10], c2_new[8:5], c2_new[3:0]};
      if (wr & hit_ts)
        tx_slot <= merge16(tx_slot, dat_i[15:0], sel_i[1:0]);
      if (wr & hit_rs)
        rx_slot <= merge16(rx_slot, dat_i[15:0], sel_i[1:0]);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // buffer registers and shadows
  always_ff @(posedge clk_i)
  begin
    for (int i = 0; i < csp_pkg::NUM_BUF; i++)
    begin
      if (rst_i)
      begin
        txbuf[i] <= csp_pkg::BUF_RST;
        rxbuf[i] <= csp_pkg::BUF_RST;
        tx_shadow[i] <= csp_pkg::BUF_RST;
        rx_shadow[i] <= csp_pkg::BUF_RST;
      end
      else
      begin
        if (wr & hit_tx & (idx == 2'(i)))
          txbuf[i] <= merge16(txbuf[i], dat_i[15:0], sel_i[1:0]);
        if (tx_move)
          tx_shadow[i] <= txbuf[i];
        if (word_done & rx_on & (bidx == 2'(i)))
          rx_shadow[i] <= rx_now;
        if (rx_move)
          rxbuf[i] <= (xfer & rx_on & (bidx == 2'(i))) ? rx_now
                                                       : rx_shadow[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // serial engine
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state <= csp_pkg::ST_IDLE;
      bit_cnt <= 4'h0;
      word_cnt <= 4'h0;
      bidx <= 2'h0;
      rx_word <= 16'h0000;
      stop_pending <= 1'b0;
      fs_prev <= 1'b0;
    end
    else
    begin
      state <= next_state;
      if (tick)
        fs_prev <= fs_s;
      if (start | enter_idle | (waiting & slave_go))
      begin
        bit_cnt <= 4'h0;
        word_cnt <= 4'h0;
        rx_word <= 16'h0000;
      end
      else if (tick & run)
      begin
        bit_cnt <= last_bit ? 4'h0 : bit_cnt + 4'h1;
        word_cnt <= frame_end ? 4'h0 : (last_bit ? word_cnt + 4'h1 : word_cnt);
        rx_word <= last_bit ? 16'h0000 : (rx_on ? rx_now : rx_word);
      end
      if (start | enter_idle)
        bidx <= 2'h0;
      else if (word_done)
        bidx <= xfer ? 2'h0 : bidx + 2'h1;
      if (start | enter_idle)
        stop_pending <= 1'b0;
      else if (stop_mark)
        stop_pending <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status flags
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tm_cnt <= 2'h0;
      transmit_empty_flag <= 1'b0;
      receive_full_flag <= 1'b0;
      receive_overflow_flag <= 1'b0;
      module_irq_flag_o <= 1'b0;
    end
    else
    begin
      tm_cnt <= start ? csp_pkg::TRANSMIT_EMPTY_FLAG_DELAY :
                (tm_cnt != 2'h0) ? tm_cnt - 2'h1 : tm_cnt;
      transmit_empty_flag <= transmit_empty_flag_set | (transmit_empty_flag & ~transmit_empty_flag_clr);
      receive_full_flag <= receive_full_flag_set | (receive_full_flag & ~receive_full_flag_clr);
      receive_overflow_flag <= (rx_move & receive_full_flag & ~receive_full_flag_clr) | (receive_overflow_flag & ~rov_clr);
      module_irq_flag_o <= receive_full_flag | transmit_empty_flag;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pins
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      frame_sync_pin_o <= 1'b0;
      frame_sync_pin_oe_o <= 1'b0;
      sdo_o <= 1'b0;
      sdo_oe_o <= 1'b0;
    end
    else
    begin
      frame_sync_pin_oe_o <= ~idle & ~ctrl.sync_dir;
      frame_sync_pin_o <= run & ~ctrl.sync_dir &
        ((ctrl.mode == csp_pkg::MODE_I2S) ? ~word_cnt[0] :
         ((word_cnt == 4'h0) & (bit_cnt == 4'h0)));
      sdo_oe_o <= ~idle;
      sdo_o <= run & tx_on & tx_shadow[bidx][~bit_cnt];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  property p_start_needs_enable;
    @(posedge clk_i) disable iff (rst_i)
    $past(idle) && !idle |-> $past(ctrl.enable);
  endproperty
  a_start_needs_enable: assert property (p_start_needs_enable)
    else $error("port left idle without enable");

  property p_transmit_empty_flag_after_enable;
    @(posedge clk_i) disable iff (rst_i)
    $past(idle) && !idle |-> ##3 transmit_empty_flag;
  endproperty
  a_transmit_empty_flag_after_enable: assert property (p_transmit_empty_flag_after_enable)
    else $error("transmit empty not set three clocks after enable");

  property p_rx_read_clears;
    @(posedge clk_i) disable iff (rst_i)
    rd && hit_rx && !receive_full_flag_set |=> !receive_full_flag;
  endproperty
  a_rx_read_clears: assert property (p_rx_read_clears)
    else $error("receive full survived buffer read");

  property p_tx_write_clears;
    @(posedge clk_i) disable iff (rst_i)
    wr && hit_tx && !transmit_empty_flag_set |=> !transmit_empty_flag;
  endproperty
  a_tx_write_clears: assert property (p_tx_write_clears)
    else $error("transmit empty survived buffer write");

  property p_irq_is_or;
    @(posedge clk_i) disable iff (rst_i)
    ##1 module_irq_flag_o == ($past(receive_full_flag) || $past(transmit_empty_flag));
  endproperty
  a_irq_is_or: assert property (p_irq_is_or)
    else $error("irq flag differs from flag OR");

  property p_idle_release;
    @(posedge clk_i) disable iff (rst_i)
    idle [*2] |-> !frame_sync_pin_oe_o && !sdo_oe_o;
  endproperty
  a_idle_release: assert property (p_idle_release)
    else $error("pins driven while idle");

  property p_disabled_stays_idle;
    @(posedge clk_i) disable iff (rst_i)
    idle && !ctrl.enable |=> idle;
  endproperty
  a_disabled_stays_idle: assert property (p_disabled_stays_idle)
    else $error("disabled port left idle");

  property p_slave_start;
    @(posedge clk_i) disable iff (rst_i)
    waiting && slave_go && !enter_idle |=>
      run && bit_cnt == 4'h0 && word_cnt == 4'h0;
  endproperty
  a_slave_start: assert property (p_slave_start)
    else $error("slave did not start frame on sync");

  property p_master_sync;
    @(posedge clk_i) disable iff (rst_i)
    run && !ctrl.sync_dir && ctrl.mode == csp_pkg::MODE_MULTI &&
      word_cnt == 4'h0 && bit_cnt == 4'h0 |=> frame_sync_pin_o;
  endproperty
  a_master_sync: assert property (p_master_sync)
    else $error("master frame sync missing at frame start");

  property p_slot_zero_idle;
    @(posedge clk_i) disable iff (rst_i)
    idle |-> status[11:7] == 5'h00;
  endproperty
  a_slot_zero_idle: assert property (p_slot_zero_idle)
    else $error("slot field nonzero while idle");

endmodule : csp_codec_port

/* File: tb/csp_codec_model.sv */
`timescale 1ns/1ns
// far-side codec: makes the bit clock, plays frame master when the port
// is slave, and collects the serial data that the port sends
module csp_codec_model (
  input wire logic run_i,
  input wire logic [5:0] len_i,
  input wire logic fs_i,
  input wire logic fs_oe_i,
  input wire logic sdo_i,
  output logic bck_o,
  output logic fs_o,
  output logic sdi_o,
  output logic [31:0] word_o,
  output logic [7:0] hi_o,
  output logic [7:0] per_o
);
  logic [31:0] cap;
  logic [7:0] cnt;
  logic mark;
  logic mark_q;
  logic fs_q;
  logic busy;
  wire start = fs_oe_i ? (fs_i && !fs_q) : mark_q;

  initial
  begin
    bck_o = 1'b0;
    fs_o = 1'b0;
    sdi_o = 1'b0;
    mark = 1'b0;
    busy = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////
  // bit clock stands low when no run is wanted
  always #40 bck_o = run_i ? ~bck_o : 1'b0;

  // one sync bit, then len_i data bits msb first
  task send_frame(input logic [31:0] w, input int glitch);
    int i;
    busy = 1'b1;
    @(negedge bck_o);
    fs_o = 1'b1;
    mark = 1'b1;
    for (i = 0; i < int'(len_i); i++)
    begin
      @(negedge bck_o);
      mark = 1'b0;
      fs_o = (i == glitch);
      sdi_o = w[31 - i];
    end
    @(negedge bck_o);
    fs_o = 1'b0;
    busy = 1'b0;
  endtask : send_frame

  // a released data line keeps changing, it never holds the last bit
  always @(negedge bck_o)
    if (!busy)
      sdi_o <= ~sdi_o;

  //////////////////////////////////////////////////////////////////////
  // collect sdo, measure sync high time and frame period
  always @(posedge bck_o)
  begin
    fs_q <= fs_i & fs_oe_i;
    mark_q <= mark;
    if (cnt == {2'b00, len_i})
      word_o <= cap;
    if (fs_i & fs_oe_i)
      hi_o <= start ? 8'h01 : hi_o + 8'h01;
    if (start)
    begin
      per_o <= cnt;
      cnt <= 8'h01;
      cap <= {31'h0, sdo_i};
    end
    else
    begin
      cnt <= cnt + 8'h01;
      cap <= {cap[30:0], sdo_i};
    end
  end
endmodule : csp_codec_model

/* File: tb/test_csp_codec_port.sv */
`timescale 1ns/1ns
module test_csp_codec_port;
  logic clk_i, rst_i, we_i, cyc_i, stb_i, ack_o;
  logic [7:0] adr_i;
  logic [31:0] dat_i, dat_o, rd, word;
  logic [3:0] sel_i;
  logic bck, fs_in, sdi, fs_o, fs_oe, sdo, sdo_oe, irq;
  logic [5:0] len;
  logic [7:0] hi, per;
  int err_total, cmp_count;

  csp_codec_port i_csp_codec_port (.clk_i(clk_i), .rst_i(rst_i),
    .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .we_i(we_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
    .bit_clock_pin_i(bck), .frame_sync_pin_i(fs_in), .sdi_i(sdi),
    .frame_sync_pin_o(fs_o), .frame_sync_pin_oe_o(fs_oe), .sdo_o(sdo),
    .sdo_oe_o(sdo_oe), .module_irq_flag_o(irq));

  csp_codec_model i_csp_codec_model (.run_i(1'b1), .len_i(len),
    .fs_i(fs_o), .fs_oe_i(fs_oe), .sdo_i(sdo), .bck_o(bck), .fs_o(fs_in),
    .sdi_o(sdi), .word_o(word), .hi_o(hi), .per_o(per));

  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////
  task finish_test;
    if (err_total == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one classic bus cycle, read data lands in rd
  task wb(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    adr_i <= a;
    dat_i <= {16'h0000, d};
    we_i <= w;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    do @(posedge clk_i); while (ack_o !== 1'b1 && ++n < 20);
    chk(32'(ack_o), 32'h1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task wait_irq(input int lim, output int n);
    n = 0;
    while (irq !== 1'b1 && n < lim)
    begin
      @(posedge clk_i);
      n++;
    end
  endtask : wait_irq

  task wait_off;
    int n;
    n = 0;
    while ((fs_oe | sdo_oe) !== 1'b0 && n < 700)
    begin
      @(posedge clk_i);
      n++;
    end
    chk(32'({fs_oe, sdo_oe}), 32'h0);
  endtask : wait_off

  ////////////////////////////////////////////////////////////////////////
  task t_reset;
    wb(1'b0, csp_pkg::ADR_CTRL_ONE, 16'h0000);
    chk(rd, 32'h0);
    wb(1'b0, csp_pkg::ADR_STATUS, 16'h0000);
    chk(rd, 32'h0);
    wb(1'b1, 8'h40, 16'hffff);
    wb(1'b0, 8'h40, 16'h0000);
    chk(rd, csp_pkg::UNMAPPED_DATA);
    chk(32'({irq, fs_oe, sdo_oe}), 32'h0);
  endtask : t_reset

  task t_master(input logic [1:0] m, input logic [7:0] hi_exp);
    int n;
    int k;
    len <= 6'd16;
    wb(1'b1, csp_pkg::ADR_CTRL_TWO, 16'h0027);
    wb(1'b1, csp_pkg::ADR_TX_SLOT, 16'h0001);
    wb(1'b1, csp_pkg::ADR_RX_SLOT, 16'h0001);
    wb(1'b1, 8'h20, 16'ha500);
    wb(1'b0, 8'h30, 16'h0000);
    wb(1'b1, csp_pkg::ADR_CTRL_ONE, {8'h80, 6'h00, m});
    chk(32'(irq), 32'h0);
    wait_irq(10, n);
    chk(32'(n > 1 && n < 6), 32'h1);
    chk(32'({fs_oe, sdo_oe}), 32'h3);
    wb(1'b1, 8'h20, 16'ha500);
    wb(1'b0, csp_pkg::ADR_STATUS, 16'h0000);
    chk(32'(rd[0]), 32'h0);
    wait_irq(400, n);
    wb(1'b0, csp_pkg::ADR_STATUS, 16'h0000);
    chk(rd & 32'h15, 32'h15);
    wb(1'b0, 8'h30, 16'h0000);
    wb(1'b0, csp_pkg::ADR_STATUS, 16'h0000);
    chk(rd & 32'h4, 32'h0);
    repeat (300) @(posedge clk_i);
    chk(32'(per), 32'd16);
    chk(32'(hi), 32'(hi_exp));
    chk(32'(word[15:8]), 32'ha5);
    wb(1'b1, csp_pkg::ADR_CTRL_ONE, {8'h00, 6'h00, m});
    wait_off;
    wb(1'b0, csp_pkg::ADR_STATUS, 16'h0000);
    chk(32'(rd[11:7]), 32'h0);
    k = 0;
    repeat (300)
    begin
      @(posedge clk_i);
      if (fs_o === 1'b1)
        k++;
    end
    chk(k, 0);
  endtask : t_master

  // 24-bit words as three 8-bit slots, far side is the frame master
  task t_slave(input logic [1:0] m);
    len <= 6'd24;
    wb(1'b1, csp_pkg::ADR_CTRL_TWO, 16'h0847);
    wb(1'b1, csp_pkg::ADR_TX_SLOT, 16'h0007);
    wb(1'b1, csp_pkg::ADR_RX_SLOT, 16'h0007);
    wb(1'b1, 8'h20, 16'ha100);
    wb(1'b1, 8'h24, 16'hb200);
    wb(1'b1, 8'h28, 16'hc300);
    wb(1'b1, csp_pkg::ADR_CTRL_ONE, {8'h81, 6'h00, m});
    repeat (20) @(posedge clk_i);
    chk(32'(fs_oe), 32'h0);
    i_csp_codec_model.send_frame(32'h5a3c9600, 9);
    repeat (20) @(posedge clk_i);
    wb(1'b0, csp_pkg::ADR_STATUS, 16'h0000);
    chk(rd & 32'h5, 32'h5);
    wb(1'b0, 8'h30, 16'h0000);
    chk(rd, 32'h5a00);
    wb(1'b0, 8'h34, 16'h0000);
    chk(rd, 32'h3c00);
    wb(1'b0, 8'h38, 16'h0000);
    chk(rd, 32'h9600);
    chk(32'(word[23:0]), 32'ha1b2c3);
    wb(1'b1, csp_pkg::ADR_CTRL_ONE, {8'h01, 6'h00, m});
    wait_off;
    i_csp_codec_model.send_frame(32'hffffffff, -1);
    repeat (20) @(posedge clk_i);
    wb(1'b0, csp_pkg::ADR_STATUS, 16'h0000);
    chk(32'({rd[11:7], rd[2]}), 32'h0);
  endtask : t_slave

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 8'h00;
    dat_i = 32'h0;
    sel_i = 4'h3;
    len = 6'd16;
    err_total = 0;
    cmp_count = 0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset;
    t_master(csp_pkg::MODE_MULTI, 8'h01);
    t_master(csp_pkg::MODE_I2S, 8'h08);
    t_master(csp_pkg::MODE_ACLINK, 8'h01);
    t_slave(csp_pkg::MODE_MULTI);
    t_slave(csp_pkg::MODE_ACLINK);
    t_slave(csp_pkg::MODE_I2S);
    finish_test;
  end

  initial
  begin
    repeat (50000) @(posedge clk_i);
    err_total++;
    finish_test;
  end
endmodule : test_csp_codec_port
